// *** shared/rstwake_pkg.sv ***
// constants, register map and types for the reset and power-down wake sequencer
package rstwake_pkg;
   // core clock: 125 MHz
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CLKS_PER_MC = 4;                  // clocks per machine cycle
   localparam logic [1:0] PHASE_C4 = 2'h3;         // last clock state of a machine cycle
   localparam logic [1:0] EXT_HOLD_MC = 2'h2;      // machine cycles held after pin falls
   localparam int WD_RESET_DELAY_CLKS = 512;        // timeout flag to watchdog reset
   localparam int WD_HOLD_MC = 2;                   // watchdog reset length, machine cycles
   localparam logic [3:0] WD_HOLD_CLKS = 4'(WD_HOLD_MC * CLKS_PER_MC);

   // register bus
   localparam int ADDR_W = 4;
   localparam logic [3:0] A_WATCHDOG_CONTROL_AND_RESET_CAUSE = 4'h0;
   localparam logic [3:0] A_POWER_CONTROL_REG = 4'h1;
   localparam logic [3:0] A_PMR = 4'h2;
   localparam logic [3:0] A_PROGRAM_MAP_REG = 4'h3;
   localparam logic [3:0] A_SP = 4'h4;
   localparam logic [3:0] A_EXT_IRQ_FLAG_REG = 4'h5;
   localparam logic [3:0] A_IRQEN = 4'h6;
   localparam logic [3:0] A_IRQLVL = 4'h7;
   localparam logic [1:0] A_PORT_HI = 2'h2;        // ports at 8..B, low bits pick port
   localparam logic [3:0] A_STATUS = 4'hC;

   // field positions
   localparam int WDC_POR = 6;                      // power-on flag
   localparam int WDC_TOUT = 3;                     // watchdog timeout flag
   localparam int WDC_WRF = 2;                      // watchdog reset flag
   localparam int WDC_EWT = 1;                      // watchdog reset enable
   localparam int WDC_RESTART = 0;                  // write 1 restarts watchdog, reads 0
   localparam int POWER_CONTROL_REG_IDLE = 0;
   localparam int POWER_CONTROL_REG_PD = 1;
   localparam int EXT_IRQ_FLAG_REG_RCW = 1;                     // rc wake select
   localparam int IRQEN_EA = 7;                     // global irq enable

   // reset values (undefined bits taken as 0)
   localparam logic [7:0] RV_SP = 8'h07;
   localparam logic [7:0] RV_PORT = 8'hFF;
   localparam logic [7:0] RV_PMR = 8'h40;
   localparam logic [7:0] RV_PROGRAM_MAP_REG = 8'h40;
   localparam logic [7:0] RV_POWER_CONTROL_REG = 8'h00;
   localparam logic [7:0] RV_EXT_IRQ_FLAG_REG = 8'h00;
   localparam logic [7:0] RV_IRQ = 8'h00;
   localparam logic [7:0] RV_WATCHDOG_CONTROL_AND_RESET_CAUSE_POR = 8'h40;
   localparam logic [7:0] WDC_EXT_KEEP = 8'h56;    // bits kept by external reset
   localparam logic [7:0] WDC_WD_KEEP = 8'h52;     // bits kept by watchdog reset
   localparam logic [7:0] WDC_WD_SET = 8'h04;      // bits set by watchdog reset

   // power-down sequencer
   typedef enum logic [1:0] {
      PS_RUN = 2'b00,
      PS_DOWN = 2'b01,
      PS_WAKE_RC = 2'b10,
      PS_WAKE_XT = 2'b11
   } pd_state_t;
endpackage

// *** design/reset_and_powerdown_wake.sv ***
// reset merge, reset-cause flags and power-down wake sequencer of the core
`timescale 1ns/1ps
module reset_and_powerdown_wake #(
   parameter int NUM_EXT = 2,
   parameter int WD_DELAY = rstwake_pkg::WD_RESET_DELAY_CLKS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic reset_pin,
   input wire logic [NUM_EXT-1:0] ext_irq_n,
   input wire logic xtal_stable,
   input wire logic ext_prog_mem,
   input wire logic instr_end,
   input wire logic wd_timeout,
   input wire logic [rstwake_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic core_reset,
   output logic pc_clear,
   output logic fetch_go,
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic xtal_osc_en,
   output logic rc_osc_en,
   output logic clk_src_rc,
   output logic strobe_hold,
   output logic ale_level,
   output logic prog_store_strobe,
   output logic p2_addr_sel,
   output logic [7:0] port0_oe_n,
   output logic [3:0][7:0] port_out,
   output logic [7:0] stack_pointer,
   output logic [NUM_EXT-1:0] wake_irq,
   output logic watchdog_reset_enable
);
   import rstwake_pkg::*;

   localparam int WDW = $clog2(WD_DELAY);
   localparam logic [WDW-1:0] WD_LAST = WDW'(WD_DELAY - 1);

   // whole state of the block
   typedef struct packed {
      logic rst_s1;                     // reset pin synchroniser
      logic rst_s2;
      logic [NUM_EXT-1:0] irq_s1;       // irq pin synchronisers
      logic [NUM_EXT-1:0] irq_s2;
      logic xt_s1;                      // crystal stable synchroniser
      logic xt_s2;
      logic [1:0] phase;                // clock state in machine cycle
      logic rst_prev;                   // previous C4 sample
      logic ext_act;                    // external reset active
      logic [1:0] ext_hold;             // machine cycles left after pin falls
      logic wd_pend;                    // timeout seen, counting to reset
      logic [WDW-1:0] wd_cnt;
      logic wd_act;                     // watchdog reset active
      logic [3:0] wd_hold;
      logic core_rst;
      logic fetch_go;
      pd_state_t pst;
      logic [7:0] watchdog_control_and_reset_cause;
      logic [7:0] power_control_reg;
      logic [7:0] power_mgmt_reg;
      logic [7:0] program_map_reg;
      logic [7:0] sp;
      logic [7:0] ext_irq_flag_reg;
      logic [7:0] irq_en;
      logic [7:0] irq_lvl;
      logic [3:0][7:0] port;
      logic [7:0] rdata;
      logic [NUM_EXT-1:0] wake;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic c4;                            // last clock of machine cycle
   logic clocks_on;                     // clocks not stopped by power-down
   logic wd_restart;                    // software restarts watchdog
   logic tout_set;                      // timeout flag event
   logic [NUM_EXT-1:0] wake_src;        // qualifying low irq pins
   logic wake_any;
   logic idle_now;
   logic pd_now;
   logic wr_watchdog_control_and_reset_cause;

   // qualifiers used by next state and outputs
   always_comb begin
      c4 = (s_q.phase == PHASE_C4);
      clocks_on = (s_q.pst != PS_DOWN);
      wr_watchdog_control_and_reset_cause = reg_wr && (reg_addr == A_WATCHDOG_CONTROL_AND_RESET_CAUSE);
      wd_restart = wr_watchdog_control_and_reset_cause && reg_wdata[WDC_RESTART];
      tout_set = wd_timeout && clocks_on && !s_q.core_rst;
      // level mode, own enable and global enable all needed
      wake_src = s_q.irq_en[NUM_EXT-1:0] & s_q.irq_lvl[NUM_EXT-1:0] & s_q.irq_s2
         & {NUM_EXT{s_q.irq_en[IRQEN_EA]}};
      wake_any = |wake_src;
      idle_now = s_q.power_control_reg[POWER_CONTROL_REG_IDLE] && (s_q.pst == PS_RUN);
      pd_now = (s_q.pst == PS_DOWN);
   end

   // next state
   always_comb begin
      s_d = s_q;
      // two-flop synchronisers for pins
      s_d.rst_s1 = reset_pin;
      s_d.rst_s2 = s_q.rst_s1;
      s_d.irq_s1 = ~ext_irq_n;
      // both stages hold 1 for a low pin, so the reset value matches an idle pin
      s_d.irq_s2 = s_q.irq_s1;
      s_d.xt_s1 = xtal_stable;
      s_d.xt_s2 = s_q.xt_s1;
      s_d.phase = s_q.phase + 2'h1;
      s_d.fetch_go = 1'b0;
      s_d.wake = '0;
      s_d.rdata = 8'h00;

      // pin sampled once per machine cycle, two high samples start reset
      if (c4) begin
         s_d.rst_prev = s_q.rst_s2;
         if (s_q.rst_s2 && (s_q.rst_prev || s_q.ext_act)) begin
            s_d.ext_act = 1'b1;
            s_d.ext_hold = EXT_HOLD_MC;
         end else if (s_q.ext_act) begin
            // pin low: count down the trailing machine cycles
            s_d.ext_hold = s_q.ext_hold - 2'h1;
            if (s_q.ext_hold == 2'h1) begin
               s_d.ext_act = 1'b0;
            end
         end
      end

      // watchdog: counter frozen while clocks are stopped
      if (wd_restart) begin
         s_d.wd_pend = 1'b0;
         s_d.wd_cnt = '0;
      end else if (tout_set && !s_q.wd_pend) begin
         s_d.wd_pend = 1'b1;
         s_d.wd_cnt = '0;
      end else if (s_q.wd_pend && clocks_on) begin
         s_d.wd_cnt = s_q.wd_cnt + WDW'(1);
         if (s_q.wd_cnt == WD_LAST) begin
            s_d.wd_pend = 1'b0;
            // reset only if enabled at expiry
            if (s_q.watchdog_control_and_reset_cause[WDC_EWT]) begin
               s_d.wd_act = 1'b1;
               s_d.wd_hold = WD_HOLD_CLKS;
            end
         end
      end
      if (s_q.wd_act) begin
         // reset held a fixed two machine cycles
         s_d.wd_hold = s_q.wd_hold - 4'h1;
         if (s_q.wd_hold == 4'h1) begin
            s_d.wd_act = 1'b0;
         end
      end

      // one merged synchronous reset
      s_d.core_rst = s_d.ext_act || s_d.wd_act;
      s_d.fetch_go = s_q.core_rst && !s_d.core_rst;

      if (s_d.core_rst) begin
         // reset loads register patterns, ram is not touched here
         s_d.sp = RV_SP;
         s_d.power_control_reg = RV_POWER_CONTROL_REG;
         s_d.power_mgmt_reg = RV_PMR;
         s_d.program_map_reg = RV_PROGRAM_MAP_REG;
         s_d.ext_irq_flag_reg = RV_EXT_IRQ_FLAG_REG;
         s_d.irq_en = RV_IRQ;
         s_d.irq_lvl = RV_IRQ;
         s_d.port = {4{RV_PORT}};
         s_d.pst = PS_RUN;
         s_d.wd_pend = 1'b0;
         s_d.wd_cnt = '0;
         // cause flags: only a watchdog reset marks itself
         if (s_d.wd_act) begin
            s_d.watchdog_control_and_reset_cause = (s_q.watchdog_control_and_reset_cause & WDC_WD_KEEP) | WDC_WD_SET;
         end else begin
            s_d.watchdog_control_and_reset_cause = s_q.watchdog_control_and_reset_cause & WDC_EXT_KEEP;
         end
      end else begin
         // register writes
         if (reg_wr) begin
            if (reg_addr[3:2] == A_PORT_HI) begin
               s_d.port[reg_addr[1:0]] = reg_wdata;
            end else begin
               unique case (reg_addr)
                  A_WATCHDOG_CONTROL_AND_RESET_CAUSE: begin
                     s_d.watchdog_control_and_reset_cause = reg_wdata & ~(8'h01 << WDC_RESTART);
                     // software may clear the power-on flag but never set it
                     s_d.watchdog_control_and_reset_cause[WDC_POR] = reg_wdata[WDC_POR] && s_q.watchdog_control_and_reset_cause[WDC_POR];
                  end
                  A_POWER_CONTROL_REG: s_d.power_control_reg = reg_wdata;
                  A_PMR: s_d.power_mgmt_reg = reg_wdata;
                  A_PROGRAM_MAP_REG: s_d.program_map_reg = reg_wdata;
                  A_SP: s_d.sp = reg_wdata;
                  A_EXT_IRQ_FLAG_REG: s_d.ext_irq_flag_reg = reg_wdata;
                  A_IRQEN: s_d.irq_en = reg_wdata;
                  A_IRQLVL: s_d.irq_lvl = reg_wdata;
                  default: ;
               endcase
            end
         end
         // timeout flag set wins over a software clear
         if (tout_set) begin
            s_d.watchdog_control_and_reset_cause[WDC_TOUT] = 1'b1;
         end
         // any qualifying irq ends idle
         if (idle_now && wake_any) begin
            s_d.power_control_reg[POWER_CONTROL_REG_IDLE] = 1'b0;
         end

         // power-down sequencer
         unique case (s_q.pst)
            PS_RUN: begin
               // enter once the setting instruction has finished
               if (s_q.power_control_reg[POWER_CONTROL_REG_PD] && instr_end) begin
                  s_d.pst = PS_DOWN;
               end
            end
            PS_DOWN: begin
               if (wake_any) begin
                  s_d.power_control_reg[POWER_CONTROL_REG_PD] = 1'b0;
                  if (s_q.ext_irq_flag_reg[EXT_IRQ_FLAG_REG_RCW]) begin
                     // run at once on rc, no crystal start-up wait
                     s_d.pst = PS_WAKE_RC;
                     s_d.wake = wake_src;
                  end else begin
                     s_d.pst = PS_WAKE_XT;
                  end
               end
            end
            PS_WAKE_RC: begin
               // hand over to crystal when stable
               if (s_q.xt_s2) begin
                  s_d.pst = PS_RUN;
               end
            end
            PS_WAKE_XT: begin
               if (s_q.xt_s2) begin
                  s_d.pst = PS_RUN;
                  s_d.wake = wake_src;
               end
            end
         endcase
      end

      // read data, one cycle after the strobe only
      if (reg_rd) begin
         if (reg_addr[3:2] == A_PORT_HI) begin
            s_d.rdata = s_q.port[reg_addr[1:0]];
         end else begin
            unique case (reg_addr)
               A_WATCHDOG_CONTROL_AND_RESET_CAUSE: s_d.rdata = s_q.watchdog_control_and_reset_cause;
               A_POWER_CONTROL_REG: s_d.rdata = s_q.power_control_reg;
               A_PMR: s_d.rdata = s_q.power_mgmt_reg;
               A_PROGRAM_MAP_REG: s_d.rdata = s_q.program_map_reg;
               A_SP: s_d.rdata = s_q.sp;
               A_EXT_IRQ_FLAG_REG: s_d.rdata = s_q.ext_irq_flag_reg;
               A_IRQEN: s_d.rdata = s_q.irq_en;
               A_IRQLVL: s_d.rdata = s_q.irq_lvl;
               A_STATUS: s_d.rdata = {3'h0, idle_now, s_q.xt_s2,
                  (s_q.pst == PS_WAKE_RC), pd_now, s_q.core_rst};
               default: s_d.rdata = 8'h00;
            endcase
         end
      end
   end

   // state register; power-on reset loads constants only
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.phase <= 2'h0;
         s_q.core_rst <= 1'b1;
         s_q.pst <= PS_RUN;
         s_q.watchdog_control_and_reset_cause <= RV_WATCHDOG_CONTROL_AND_RESET_CAUSE_POR;
         s_q.power_control_reg <= RV_POWER_CONTROL_REG;
         s_q.power_mgmt_reg <= RV_PMR;
         s_q.program_map_reg <= RV_PROGRAM_MAP_REG;
         s_q.sp <= RV_SP;
         s_q.ext_irq_flag_reg <= RV_EXT_IRQ_FLAG_REG;
         s_q.irq_en <= RV_IRQ;
         s_q.irq_lvl <= RV_IRQ;
         s_q.port <= {4{RV_PORT}};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   always_comb begin
      reg_rdata = s_q.rdata;
      core_reset = s_q.core_rst;
      pc_clear = s_q.core_rst;
      fetch_go = s_q.fetch_go;
      core_clk_en = (s_q.pst == PS_RUN || s_q.pst == PS_WAKE_RC) && !idle_now;
      periph_clk_en = (s_q.pst == PS_RUN || s_q.pst == PS_WAKE_RC);
      xtal_osc_en = !pd_now;
      rc_osc_en = (s_q.pst == PS_WAKE_RC);
      clk_src_rc = (s_q.pst == PS_WAKE_RC);
      strobe_hold = idle_now || pd_now;
      ale_level = idle_now;
      prog_store_strobe = idle_now;
      p2_addr_sel = ext_prog_mem && idle_now;
      // port 0 has no pull-ups: a 1 floats
      port0_oe_n = s_q.port[0] | {8{ext_prog_mem && (idle_now || pd_now)}};
      port_out = s_q.port;
      stack_pointer = s_q.sp;
      wake_irq = s_q.wake;
      watchdog_reset_enable = s_q.watchdog_control_and_reset_cause[WDC_EWT];
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence pin_seen_s;
      c4 && s_q.rst_s2 && s_q.rst_prev;
   endsequence
   sequence wd_expire_s;
      s_q.wd_pend && !wd_restart && clocks_on && s_q.watchdog_control_and_reset_cause[WDC_EWT] && (s_q.wd_cnt == WD_LAST);
   endsequence

   pin_detect_a: assert property (pin_seen_s |=> s_q.ext_act ##0 core_reset)
      else $error("two high reset samples did not start reset");
   pin_hold_a: assert property (c4 && s_q.ext_act && s_q.rst_s2 |=> core_reset[*4])
      else $error("reset released while pin still high");
   release_go_a: assert property ($fell(core_reset) |-> fetch_go)
      else $error("no fetch start on reset release");
   wd_delay_a: assert property (wd_expire_s |=> s_q.wd_act ##0 core_reset)
      else $error("watchdog reset missing after delay");
   wd_hold_a: assert property ($rose(s_q.wd_act) |-> s_q.wd_act[*8] ##1 !s_q.wd_act)
      else $error("watchdog reset length wrong");
   wd_flag_a: assert property ($rose(s_q.wd_act) |-> s_q.watchdog_control_and_reset_cause[WDC_WRF] && !s_q.watchdog_control_and_reset_cause[WDC_TOUT])
      else $error("watchdog cause flag not set");
   ext_noflag_a: assert property ($rose(s_q.ext_act) && !s_q.wd_act
      |-> s_q.watchdog_control_and_reset_cause[WDC_WRF] == $past(s_q.watchdog_control_and_reset_cause[WDC_WRF]))
      else $error("external reset changed a cause flag");
   por_flag_a: assert property (!s_q.watchdog_control_and_reset_cause[WDC_POR] |=> !s_q.watchdog_control_and_reset_cause[WDC_POR])
      else $error("power-on flag set without power-on");
   reset_vals_a: assert property (core_reset |-> stack_pointer == RV_SP
      && port_out == {4{RV_PORT}} && port0_oe_n == RV_PORT)
      else $error("reset values not loaded");
   pd_wdog_a: assert property (pd_now && !s_q.wd_act |=> !s_q.wd_act)
      else $error("watchdog reset raised in power-down");
   pd_wake_a: assert property (pd_now && wake_any |=> !pd_now)
      else $error("qualified irq did not wake");
   pd_stay_a: assert property (pd_now && !wake_any && !s_d.core_rst |=> pd_now)
      else $error("left power-down without cause");
   pd_strobe_a: assert property (pd_now |-> strobe_hold && !ale_level && !prog_store_strobe)
      else $error("strobes not low in power-down");
   rc_wake_a: assert property (s_q.pst == PS_WAKE_RC && s_q.xt_s2 && !s_d.core_rst
      |=> !clk_src_rc && core_clk_en)
      else $error("no switch from rc to crystal");
endmodule

// *** testbench/reset_irq_partner.sv ***
// far-side model: external reset source, interrupt pins and crystal warm-up
`timescale 1ns/1ps
module reset_irq_partner #(
   parameter int NUM_EXT = 2,
   parameter int XTAL_WARM = 10 // clocks the crystal needs to settle
) (
   input wire logic ref_clk,
   input wire logic xtal_osc_en,
   output logic reset_pin,
   output logic [NUM_EXT-1:0] ext_irq_n,
   output logic xtal_stable
);
   int warm_q = XTAL_WARM; // crystal warm-up count, starts settled
   initial begin
      reset_pin = 1'b0;
      ext_irq_n = '1;
   end
   // crystal only settles after running a while; stops at once when off
   always @(posedge ref_clk) begin
      if (xtal_osc_en !== 1'b1) begin
         warm_q <= 0;
      end else if (warm_q < XTAL_WARM) begin
         warm_q <= warm_q + 1;
      end
   end
   assign xtal_stable = (warm_q >= XTAL_WARM);
   // reset pin held for whole machine cycles of four clocks
   task pin_pulse(input int mcs);
      @(posedge ref_clk);
      reset_pin <= 1'b1;
      repeat (mcs * 4) @(posedge ref_clk);
      reset_pin <= 1'b0;
   endtask
   // level request, held until the bench releases it
   task irq_set(input int idx, input logic lvl);
      @(posedge ref_clk);
      ext_irq_n[idx] <= lvl;
   endtask
endmodule

// *** testbench/reset_and_powerdown_wake_tb.sv ***
// self-checking bench of the reset and power-down wake sequencer
`timescale 1ns/1ps
module reset_and_powerdown_wake_tb;
   import rstwake_pkg::*;
   localparam int WD_DLY = 16; // shortened watchdog delay
   logic ref_clk, rst_n, reset_pin, xtal_stable, ext_prog_mem, instr_end, wd_timeout;
   logic reg_wr, reg_rd, core_reset, pc_clear, fetch_go, core_clk_en, periph_clk_en;
   logic xtal_osc_en, rc_osc_en, clk_src_rc, strobe_hold, ale_level, prog_store_strobe;
   logic p2_addr_sel, watchdog_reset_enable, hit;
   logic [1:0] ext_irq_n, wake_irq;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, port0_oe_n, stack_pointer, rd_v, prior;
   logic [3:0][7:0] port_out;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;

   reset_and_powerdown_wake #(.NUM_EXT(2), .WD_DELAY(WD_DLY)) reset_and_powerdown_wake_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .reset_pin(reset_pin), .ext_irq_n(ext_irq_n),
      .xtal_stable(xtal_stable), .ext_prog_mem(ext_prog_mem), .instr_end(instr_end),
      .wd_timeout(wd_timeout), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_reset(core_reset),
      .pc_clear(pc_clear), .fetch_go(fetch_go), .core_clk_en(core_clk_en),
      .periph_clk_en(periph_clk_en), .xtal_osc_en(xtal_osc_en), .rc_osc_en(rc_osc_en),
      .clk_src_rc(clk_src_rc), .strobe_hold(strobe_hold), .ale_level(ale_level),
      .prog_store_strobe(prog_store_strobe), .p2_addr_sel(p2_addr_sel),
      .port0_oe_n(port0_oe_n), .port_out(port_out), .stack_pointer(stack_pointer),
      .wake_irq(wake_irq), .watchdog_reset_enable(watchdog_reset_enable));

   reset_irq_partner #(.NUM_EXT(2), .XTAL_WARM(10)) reset_irq_partner_inst (
      .ref_clk(ref_clk), .xtal_osc_en(xtal_osc_en), .reset_pin(reset_pin),
      .ext_irq_n(ext_irq_n), .xtal_stable(xtal_stable));

   // core clock, 8 ns period
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // hang guard: the tests need far fewer cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         $display("BAD t=%0t cycle limit reached", $time);
         stop_test();
      end
   end

   // verdict and end of run
   task stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // compare one value
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // one-cycle read strobe, data looked at in the following cycle only
   task rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask = 8'hFF);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
      chk(rd_v & mask, exp);
   endtask

   // pulses from the core and the watchdog timer
   task end_pulse();
      @(posedge ref_clk);
      instr_end <= 1'b1;
      @(posedge ref_clk);
      instr_end <= 1'b0;
   endtask
   task wd_pulse();
      @(posedge ref_clk);
      wd_timeout <= 1'b1;
      @(posedge ref_clk);
      wd_timeout <= 1'b0;
   endtask

   // count cycles until internal reset reaches a level
   task wait_cr(input logic lvl);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (core_reset !== lvl && n < 60);
   endtask

   // internal reset must stay low for a number of cycles
   task quiet(input int cycles);
      hit = 1'b0;
      repeat (cycles) begin
         @(posedge ref_clk);
         #1;
         hit = hit | core_reset;
      end
      chk(8'(hit), 8'h00);
   endtask

   // power-down entry, refused wake on pin 1, wake on pin 0
   task pd_cycle(input logic rc, input logic [7:0] en, input logic [7:0] lvl);
      wr(A_IRQEN, en);
      wr(A_IRQLVL, lvl);
      wr(A_EXT_IRQ_FLAG_REG, {6'h00, rc, 1'b0});
      wr(A_POWER_CONTROL_REG, 8'h02);
      end_pulse();
      wd_pulse();
      repeat (2) @(posedge ref_clk);
      #1;
      chk({periph_clk_en, rc_osc_en, core_clk_en, xtal_osc_en, strobe_hold, ale_level,
           prog_store_strobe, p2_addr_sel}, 8'h08);
      chk(port0_oe_n, 8'hFF);
      reset_irq_partner_inst.irq_set(1, 1'b0);
      repeat (30) @(posedge ref_clk);
      #1;
      chk({6'h00, core_reset, core_clk_en}, 8'h00);
      rd(A_STATUS, 8'h02);
      reset_irq_partner_inst.irq_set(1, 1'b1);
      // pin 0 qualifies except for the cleared global enable
      wr(A_IRQEN, en & 8'h7F);
      reset_irq_partner_inst.irq_set(0, 1'b0);
      repeat (8) @(posedge ref_clk);
      #1;
      chk({6'h00, core_clk_en, xtal_osc_en}, 8'h00);
      wr(A_IRQEN, en);
      n = 0;
      while (wake_irq[0] !== 1'b1 && n < 60) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk({2'h0, periph_clk_en, wake_irq[1], rc_osc_en, wake_irq[0], core_clk_en, clk_src_rc},
          {2'h0, 1'b1, 1'b0, rc, 2'b11, rc});
      n = 0;
      while (clk_src_rc !== 1'b0 && n < 60) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk({6'h00, clk_src_rc, xtal_stable}, 8'h01);
      reset_irq_partner_inst.irq_set(0, 1'b1);
      rd(A_POWER_CONTROL_REG, 8'h00);
      $display("power-down wake test done, rc %0b", rc);
   endtask

   // main sequence
   initial begin
      rst_n <= 1'b0;
      ext_prog_mem <= 1'b0;
      instr_end <= 1'b0;
      wd_timeout <= 1'b0;
      reg_addr <= 4'h0;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(A_WATCHDOG_CONTROL_AND_RESET_CAUSE, 8'h40);
      rd(A_SP, 8'h07);
      rd(A_PMR, 8'h40);
      rd(A_PROGRAM_MAP_REG, 8'h40);
      rd(A_IRQEN, 8'h00);
      rd(4'hD, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rd(4'h8 + 4'(i), 8'hFF);
      end
      chk({6'h00, core_reset, watchdog_reset_enable}, 8'h00);
      $display("power-on test done");
      // a one machine cycle pin pulse is too short
      reset_irq_partner_inst.pin_pulse(1);
      quiet(20);
      $display("short pin test done");
      // idle with external program memory, left by a qualifying irq
      @(posedge ref_clk);
      ext_prog_mem <= 1'b1;
      wr(A_WATCHDOG_CONTROL_AND_RESET_CAUSE, 8'h02);
      wr(A_IRQEN, 8'h81);
      wr(A_IRQLVL, 8'h01);
      wr(A_POWER_CONTROL_REG, 8'h01);
      end_pulse();
      repeat (2) @(posedge ref_clk);
      #1;
      chk({3'h0, strobe_hold, ale_level, prog_store_strobe, p2_addr_sel, core_clk_en},
          8'h1E);
      chk(port0_oe_n, 8'hFF);
      reset_irq_partner_inst.irq_set(0, 1'b0);
      n = 0;
      while (core_clk_en !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(8'(core_clk_en), 8'h01);
      reset_irq_partner_inst.irq_set(0, 1'b1);
      $display("idle test done");
      pd_cycle(1'b1, 8'h81, 8'h03);
      pd_cycle(1'b0, 8'h83, 8'h01);
      @(posedge ref_clk);
      ext_prog_mem <= 1'b0;
      // watchdog reset
      wr(A_SP, 8'h30);
      wr(4'h9, 8'h5A);
      wd_pulse();
      wait_cr(1'b1);
      chk(8'(n), 8'(WD_DLY));
      chk({6'h00, pc_clear, fetch_go}, 8'h02);
      wait_cr(1'b0);
      chk(8'(n), 8'h08);
      chk(8'(fetch_go), 8'h01);
      rd(A_WATCHDOG_CONTROL_AND_RESET_CAUSE, 8'h06);
      rd(A_SP, 8'h07);
      rd(4'h9, 8'hFF);
      rd(A_IRQEN, 8'h00);
      chk(stack_pointer, 8'h07);
      $display("watchdog reset test done");
      // restarting the watchdog cancels the pending reset
      wd_pulse();
      rd(A_WATCHDOG_CONTROL_AND_RESET_CAUSE, 8'h08, 8'h08);
      wr(A_WATCHDOG_CONTROL_AND_RESET_CAUSE, 8'h43);
      quiet(40);
      $display("watchdog restart test done");
      // valid external reset
      rd(A_WATCHDOG_CONTROL_AND_RESET_CAUSE, 8'h02, 8'h4A);
      prior = rd_v;
      reset_irq_partner_inst.pin_pulse(3);
      #1;
      chk(8'(core_reset), 8'h01);
      wait_cr(1'b0);
      // last high C4 sample lands 0..3 clocks before the pin's fall is seen, then 2 machine cycles
      chk(8'(n >= 7 && n <= 10), 8'h01);
      chk(8'(fetch_go), 8'h01);
      rd(A_WATCHDOG_CONTROL_AND_RESET_CAUSE, prior & 8'h56);
      $display("external reset test done");
      // second power-on reset in mid-run
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(A_WATCHDOG_CONTROL_AND_RESET_CAUSE, 8'h40);
      chk(8'(watchdog_reset_enable), 8'h00);
      $display("second power-on test done");
      stop_test();
   end
endmodule
